//--- pkg/srw_pkg.sv
// Purpose: shared constants for the reset sequencer and watchdog
// Assumes: 200 MHz system clock, byte-wide registers on a 32-bit bus
// Notes:   long counts become top-level parameters with these defaults
package srw_pkg;
	// ----------------------------------------------------------------
	// clock and timing
	// ----------------------------------------------------------------
	localparam int unsigned     CLK_HZ         = 200_000_000;
	localparam int unsigned     CLK_MHZ        = CLK_HZ / 1_000_000;
	localparam int unsigned     WDOSC_HZ       = 128_000;
	localparam int unsigned     WD_DIV_CYC     = CLK_HZ / WDOSC_HZ;
	localparam longint unsigned TOUT_SHORT_MS  = 4;
	localparam longint unsigned TOUT_LONG_MS   = 64;
	localparam longint unsigned TOUT_SHORT_CYC = TOUT_SHORT_MS * CLK_HZ / 1000;
	localparam longint unsigned TOUT_LONG_CYC  = TOUT_LONG_MS * CLK_HZ / 1000;
	localparam int unsigned     TOUT_MIN_CYC   = 16;
	localparam int unsigned     CLOCK_SELECT_FUSE_XTRA_CYC = 6;
	localparam int unsigned     EXT_MIN_NS     = 2500;
	localparam int unsigned     BOD_MIN_NS     = 2000;
	localparam int unsigned     EXT_MIN_CYC    = (EXT_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned     BOD_MIN_CYC    = (BOD_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned     DLY_W          = 24;
	localparam int unsigned     FILT_W         = 12;
	localparam int unsigned     WDCNT_W        = 21;
	localparam int unsigned     WD_BASE_CYC    = 2048;
	localparam logic [3:0]      WDP_MAX        = 4'h9;
	localparam logic [2:0]      WATCHDOG_CHANGE_ENABLE_HOLD_CYC  = 3'h4;
	// ----------------------------------------------------------------
	// fuse codes
	// ----------------------------------------------------------------
	localparam logic [1:0]      SUT_MIN        = 2'h0;
	localparam logic [1:0]      SUT_SHORT      = 2'h1;
	localparam logic [3:0]      CLOCK_SELECT_FUSE_EXTCLK   = 4'h0;
	// ----------------------------------------------------------------
	// register map and fields
	// ----------------------------------------------------------------
	localparam logic [3:0]      REG_STATUS     = 4'h0;
	localparam logic [3:0]      REG_WDCTL      = 4'h4;
	localparam logic [3:0]      REG_SEQ        = 4'h8;
	localparam int unsigned     ST_POWER_ON_FLAG        = 0;
	localparam int unsigned     ST_EXTRF       = 1;
	localparam int unsigned     ST_BORF        = 2;
	localparam int unsigned     ST_WATCHDOG_RESET_FLAG        = 3;
	localparam int unsigned     WD_E           = 3;
	localparam int unsigned     WD_CE          = 4;
	localparam int unsigned     WD_P3          = 5;
	localparam int unsigned     WD_IE          = 6;
	localparam int unsigned     WD_IF          = 7;
	localparam logic [1:0]      RESP_OKAY      = 2'h0;
	localparam logic [1:0]      RESP_SLVERR    = 2'h2;
	typedef enum logic [1:0] {
		SQ_HOLD  = 2'b00,
		SQ_DELAY = 2'b01,
		SQ_RUN   = 2'b10
	} srw_seq_e;
endpackage

//--- verilog/srw_reset_watchdog.sv
// Purpose: reset source combiner, start-up delay, watchdog, reset flags
// Assumes: one clock; the watchdog oscillator is an enable divided from it
// Notes:   registers over AXI4-Lite, one byte per aligned word
`timescale 1ns/1ps
module srw_reset_watchdog
	import srw_pkg::*;
#(
	parameter int unsigned DELAY_MIN_CYC   = srw_pkg::TOUT_MIN_CYC,
	parameter int unsigned DELAY_SHORT_CYC = 32'(srw_pkg::TOUT_SHORT_CYC),
	parameter int unsigned DELAY_LONG_CYC  = 32'(srw_pkg::TOUT_LONG_CYC),
	parameter int unsigned WD_DIV          = srw_pkg::WD_DIV_CYC
)(
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        porActive,
	input  wire logic        resetPinN,
	input  wire logic        resetPinEnable,
	input  wire logic        brownoutBelow,
	input  wire logic        brownoutEnableFuse,
	input  wire logic [1:0]  startupTimeFuse,
	input  wire logic [3:0]  clockSelectFuse,
	input  wire logic        watchdogAlwaysOnFuse,
	input  wire logic        watchdogRestart,
	input  wire logic        watchdogIrqAck,
	input  wire logic        comparatorBandgapSelect,
	input  wire logic        adcEnable,
	output logic             chipResetN,
	output logic             ioResetN,
	output logic             watchdogIrq,
	output logic             bandgapEnable,
	input  wire logic [3:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [3:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready
);
	import srw_pkg::*;

	initial
	begin
		if (WD_DIV < 2 || DELAY_MIN_CYC < 1)
			$error("divider and minimum delay must be at least two and one");
		if (64'(DELAY_LONG_CYC) + 64'(CLOCK_SELECT_FUSE_XTRA_CYC) >= (64'h1 << DLY_W))
			$error("delay counts do not fit the delay counter");
	end

	// ----------------------------------------------------------------
	// reset sources
	// ----------------------------------------------------------------
	logic [FILT_W-1:0] extCntQ;
	logic [FILT_W-1:0] bodCntQ;
	logic              wdPulseQ;
	wire               extLow   = resetPinEnable & ~resetPinN;
	wire               bodLow   = brownoutEnableFuse & brownoutBelow;
	wire               extTrig  = extCntQ == FILT_W'(EXT_MIN_CYC);
	wire               bodTrig  = bodCntQ == FILT_W'(BOD_MIN_CYC);
	wire               srcActive = porActive | extTrig | bodTrig | wdPulseQ;

	always_ff @(posedge clk)
	begin
		if (!nrst || !extLow)
			extCntQ <= '0;
		else if (!extTrig)
			extCntQ <= extCntQ + 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (!nrst || !bodLow)
			bodCntQ <= '0;
		else if (!bodTrig)
			bodCntQ <= bodCntQ + 1'b1;
	end

	// ----------------------------------------------------------------
	// start-up delay sequencer
	// ----------------------------------------------------------------
	srw_seq_e          seqQ;
	srw_seq_e          seqD;
	logic [DLY_W-1:0]  dlyCntQ;
	wire [DLY_W-1:0]   sutCyc = (startupTimeFuse == SUT_MIN)   ? DLY_W'(DELAY_MIN_CYC) :
	                            (startupTimeFuse == SUT_SHORT) ? DLY_W'(DELAY_SHORT_CYC) :
	                                                             DLY_W'(DELAY_LONG_CYC);
	wire [DLY_W-1:0]   delayLoad = sutCyc + ((clockSelectFuse == CLOCK_SELECT_FUSE_EXTCLK) ?
	                                         DLY_W'(0) : DLY_W'(CLOCK_SELECT_FUSE_XTRA_CYC));
	wire               inReset = seqQ != SQ_RUN;

	always_comb
	begin
		seqD = seqQ;
		case (seqQ)
			SQ_HOLD:  seqD = srcActive ? SQ_HOLD : SQ_DELAY;
			SQ_DELAY: seqD = srcActive ? SQ_HOLD : (dlyCntQ == '0) ? SQ_RUN : SQ_DELAY;
			SQ_RUN:   seqD = srcActive ? SQ_HOLD : SQ_RUN;
			default:  seqD = SQ_HOLD;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			seqQ       <= SQ_HOLD;
			dlyCntQ    <= '0;
			chipResetN <= 1'b0;
			ioResetN   <= 1'b0;
		end
		else
		begin
			seqQ       <= seqD;
			// count starts when the last source drops, incl. the pulse's falling edge
			dlyCntQ    <= (seqQ == SQ_HOLD) ? delayLoad - 1'b1 : dlyCntQ - 1'b1;
			chipResetN <= seqD == SQ_RUN;
			ioResetN   <= ~srcActive;
		end
	end

	// ----------------------------------------------------------------
	// register bus
	// ----------------------------------------------------------------
	logic        awHeldQ;
	logic        wHeldQ;
	logic [3:0]  awAddrQ;
	logic [7:0]  wByteQ;
	logic        wLaneQ;
	logic [3:0]  rflagsQ;
	logic        wdifQ;
	logic        wdieQ;
	logic        wdeQ;
	logic        wdceQ;
	logic [3:0]  wdpQ;
	logic [2:0]  wdceCntQ;
	wire         wrFire   = awHeldQ & wHeldQ & ~bvalid;
	wire         wrMapped = awAddrQ[3:2] <= REG_SEQ[3:2];
	wire         wrStatus = wrFire & wLaneQ & (awAddrQ[3:2] == REG_STATUS[3:2]);
	wire         wrWdctl  = wrFire & wLaneQ & (awAddrQ[3:2] == REG_WDCTL[3:2]);
	wire         level2   = watchdogAlwaysOnFuse;
	wire         wdeEff   = level2 | wdeQ | rflagsQ[ST_WATCHDOG_RESET_FLAG];
	wire [7:0]   wdctlRd  = {wdifQ, wdieQ, wdpQ[3], wdceQ, wdeEff, wdpQ[2:0]};
	wire [7:0]   seqRd    = {5'h00, level2, seqQ == SQ_DELAY, inReset};
	wire         rdMapped = araddr[3:2] <= REG_SEQ[3:2];
	wire [7:0]   rdByte   = (araddr[3:2] == REG_STATUS[3:2]) ? {4'h0, rflagsQ} :
	                        (araddr[3:2] == REG_WDCTL[3:2])  ? wdctlRd : seqRd;

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			awready <= 1'b0;
			wready  <= 1'b0;
			awHeldQ <= 1'b0;
			wHeldQ  <= 1'b0;
			awAddrQ <= '0;
			wByteQ  <= '0;
			wLaneQ  <= 1'b0;
			bvalid  <= 1'b0;
			bresp   <= RESP_OKAY;
		end
		else
		begin
			awready <= awvalid & ~awready & ~awHeldQ & ~bvalid;
			wready  <= wvalid & ~wready & ~wHeldQ & ~bvalid;
			if (awvalid && awready)
			begin
				awHeldQ <= 1'b1;
				awAddrQ <= awaddr;
			end
			if (wvalid && wready)
			begin
				wHeldQ <= 1'b1;
				wByteQ <= wdata[7:0];
				wLaneQ <= wstrb[0];
			end
			if (wrFire)
			begin
				awHeldQ <= 1'b0;
				wHeldQ  <= 1'b0;
				bvalid  <= 1'b1;
				bresp   <= wrMapped ? RESP_OKAY : RESP_SLVERR;
			end
			else if (bready)
				bvalid <= 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= '0;
			rresp   <= RESP_OKAY;
		end
		else
		begin
			arready <= arvalid & ~arready & ~rvalid;
			if (arvalid && arready)
			begin
				rvalid <= 1'b1;
				rdata  <= rdMapped ? {24'h000000, rdByte} : 32'h00000000;
				rresp  <= rdMapped ? RESP_OKAY : RESP_SLVERR;
			end
			else if (rready)
				rvalid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// reset cause flags: a cause in the clearing cycle still sets
	// ----------------------------------------------------------------
	wire [3:0] flagClr = wrStatus ? ~wByteQ[3:0] : 4'h0;
	wire [3:0] flagSet = {wdPulseQ, bodTrig, extTrig, porActive};

	always_ff @(posedge clk)
	begin
		if (!nrst)
			rflagsQ <= '0;
		else if (porActive)
			rflagsQ <= 4'h1 << ST_POWER_ON_FLAG;
		else
			rflagsQ <= (rflagsQ & ~flagClr) | flagSet;
	end

	// ----------------------------------------------------------------
	// watchdog control, safety levels and timed sequence
	// ----------------------------------------------------------------
	logic              wdExpQ;
	wire               wdceSet  = wrWdctl & wByteQ[WD_CE] & wByteQ[WD_E];
	wire [3:0]         wdpWr    = {wByteQ[WD_P3], wByteQ[2:0]};
	wire               wdpOk    = ~level2 | wdceQ;
	wire               wdeClrOk = wdceQ & ~level2;

	always_ff @(posedge clk)
	begin
		if (!nrst || inReset)
		begin
			// chip reset brings control back to its initial values
			wdieQ    <= 1'b0;
			wdeQ     <= 1'b0;
			wdpQ     <= '0;
			wdceQ    <= 1'b0;
			wdceCntQ <= '0;
		end
		else
		begin
			if (wdceSet)
			begin
				wdceQ    <= 1'b1;
				wdceCntQ <= WATCHDOG_CHANGE_ENABLE_HOLD_CYC - 1'b1;
			end
			else if (wdceQ)
			begin
				wdceCntQ <= wdceCntQ - 1'b1;
				wdceQ    <= wdceCntQ != '0;
			end
			if (wrWdctl && (wByteQ[WD_E] || wdeClrOk))
				wdeQ <= wByteQ[WD_E];
			if (wrWdctl && wdpOk)
				wdpQ <= wdpWr;
			if (wdExpQ && wdieQ && wdeEff)
				wdieQ <= 1'b0;  // reset stays armed behind one interrupt
			else if (wrWdctl)
				wdieQ <= wByteQ[WD_IE];
		end
	end

	always_ff @(posedge clk)
	begin
		if (!nrst || inReset)
			wdifQ <= 1'b0;
		else if (wdExpQ && wdieQ)
			wdifQ <= 1'b1;
		else if (watchdogIrqAck || (wrWdctl && wByteQ[WD_IF]))
			wdifQ <= 1'b0;
	end

	// ----------------------------------------------------------------
	// watchdog counter on the divided oscillator tick
	// ----------------------------------------------------------------
	logic [15:0]        divCntQ;
	logic               tickQ;
	logic [WDCNT_W-1:0] wdCntQ;
	wire                wdRun    = wdeEff | wdieQ;
	wire [3:0]          wdpUse   = (wdpQ > WDP_MAX) ? WDP_MAX : wdpQ;
	wire [WDCNT_W-1:0]  wdLimit  = (WDCNT_W'(WD_BASE_CYC) << wdpUse) - 1'b1;
	wire                wdExpire = tickQ & wdRun & (wdCntQ == wdLimit);

	always_ff @(posedge clk)
	begin
		if (!nrst || divCntQ == 16'(WD_DIV - 1))
			divCntQ <= '0;
		else
			divCntQ <= divCntQ + 1'b1;
		tickQ <= nrst && divCntQ == 16'(WD_DIV - 1);
	end

	always_ff @(posedge clk)
	begin
		if (!nrst || inReset || !wdRun || watchdogRestart)
			wdCntQ <= '0;
		else if (tickQ)
			wdCntQ <= (wdCntQ == wdLimit) ? '0 : wdCntQ + 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			wdExpQ        <= 1'b0;
			wdPulseQ      <= 1'b0;
			watchdogIrq   <= 1'b0;
			bandgapEnable <= 1'b0;
		end
		else
		begin
			wdExpQ        <= wdExpire & ~watchdogRestart;
			wdPulseQ      <= wdExpQ & wdeEff & ~wdieQ;
			watchdogIrq   <= wdifQ;
			bandgapEnable <= brownoutEnableFuse | comparatorBandgapSelect | adcEnable;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	src_hold_a: assert property (srcActive |=> !chipResetN)
		else $error("chip reset not asserted with an active source");
	dly_stretch_a: assert property ($fell(srcActive) |=> !chipResetN ##1 !chipResetN)
		else $error("reset released without delay");
	io_follow_a: assert property (srcActive |=> !ioResetN)
		else $error("io reset missed an active source");
	wd_pulse_a: assert property (wdPulseQ |=> !wdPulseQ)
		else $error("watchdog reset pulse longer than one clock");
	wd_expire_a: assert property (wdExpQ && wdeEff && !wdieQ |=> wdPulseQ ##2 seqQ == SQ_DELAY)
		else $error("expiry did not reset and start the delay");
	watchdog_change_enable_clear_a: assert property (wdceSet ##1 (!wdceSet)[*4] |=> !wdceQ)
		else $error("change enable not cleared after four clocks");
	level_two_a: assert property (level2 |-> wdeEff)
		else $error("watchdog disabled at safety level two");
	por_flags_a: assert property (porActive |=> rflagsQ == 4'h1)
		else $error("power-on did not reset the cause flags");
	bandgap_or_a: assert property (##1 bandgapEnable == $past(brownoutEnableFuse
		| comparatorBandgapSelect | adcEnable))
		else $error("bandgap enable is not the OR of its conditions");
	wd_restart_a: assert property (watchdogRestart |=> wdCntQ == '0)
		else $error("restart did not clear the watchdog counter");

	cv_wd_reset: cover property (wdPulseQ ##[1:40] chipResetN);
	cv_wd_irq: cover property ($rose(watchdogIrq));
	cv_ext_reset: cover property ($rose(extTrig));
	cv_bod_short: cover property ($fell(bodLow) && bodCntQ != '0 && !bodTrig);
endmodule

//--- sim/srw_core_model.sv
// Purpose: core side that takes the watchdog interrupt
// Assumes: the interrupt vector runs one clock after the flag is seen
// Notes:   never acknowledges while the chip is held in reset
`timescale 1ns/1ps
module srw_core_model (
	input  wire logic clk,
	input  wire logic chipResetN,
	input  wire logic watchdogIrq,
	output logic      watchdogIrqAck
);
	// ----------------------------------------------------------------
	// interrupt acknowledge
	// ----------------------------------------------------------------
	initial watchdogIrqAck = 1'b0;
	// one-cycle pulse, repeated on alternate clocks while the flag is still seen high
	always @(posedge clk)
	begin
		watchdogIrqAck <= watchdogIrq && chipResetN && !watchdogIrqAck;
	end
endmodule

//--- sim/testbench.sv
// Purpose: self-checking bench for the reset sequencer and watchdog
// Assumes: short delay parameters, minimum start-up fuse (delay D)
// Notes:   cycle windows allow for the watchdog tick phase
`timescale 1ns/1ps
module testbench;
	import srw_pkg::*;
	localparam int unsigned D    = 4;
	localparam int unsigned WDIV = 4;
	localparam int unsigned WPER = 2048 * WDIV;
	logic        clk = 1'b0;
	logic        nrst, porActive, resetPinN, resetPinEnable, brownoutBelow;
	logic        brownoutEnableFuse, watchdogAlwaysOnFuse, watchdogRestart;
	logic        comparatorBandgapSelect, adcEnable, watchdogIrqAck;
	logic [1:0]  startupTimeFuse;
	logic [3:0]  clockSelectFuse, awaddr, araddr, wstrb;
	logic        awvalid, wvalid, bready, arvalid, rready;
	logic [31:0] wdata, rdata;
	logic        chipResetN, ioResetN, watchdogIrq, bandgapEnable;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	int          badCount = 0;
	int          cmpCount = 0;
	always #2.5 clk = ~clk;
	srw_reset_watchdog #(.DELAY_MIN_CYC(D), .DELAY_SHORT_CYC(20), .DELAY_LONG_CYC(40),
		.WD_DIV(WDIV)) u_dut (.clk(clk), .nrst(nrst), .porActive(porActive),
		.resetPinN(resetPinN), .resetPinEnable(resetPinEnable), .brownoutBelow(brownoutBelow),
		.brownoutEnableFuse(brownoutEnableFuse), .startupTimeFuse(startupTimeFuse),
		.clockSelectFuse(clockSelectFuse), .watchdogAlwaysOnFuse(watchdogAlwaysOnFuse),
		.watchdogRestart(watchdogRestart), .watchdogIrqAck(watchdogIrqAck),
		.comparatorBandgapSelect(comparatorBandgapSelect), .adcEnable(adcEnable),
		.chipResetN(chipResetN), .ioResetN(ioResetN), .watchdogIrq(watchdogIrq),
		.bandgapEnable(bandgapEnable), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
	srw_core_model u_core (.clk(clk), .chipResetN(chipResetN), .watchdogIrq(watchdogIrq),
		.watchdogIrqAck(watchdogIrqAck));
	// ----------------------------------------------------------------
	// checking and bus tasks
	// ----------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
		cmpCount++;
		if (got !== exp)
		begin
			badCount++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic axw(input logic [3:0] a, input logic [7:0] d, output logic [1:0] resp);
		bit aw;
		bit w;
		int n;
		aw = 1'b0;
		w = 1'b0;
		n = 0;
		@(posedge clk);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (bvalid !== 1'b1 && n < 60)
		begin
			@(posedge clk);
			n++;
			if (awready === 1'b1)
				aw = 1'b1;
			if (wready === 1'b1)
				w = 1'b1;
			awvalid <= !aw;
			wvalid <= !w;
		end
		resp = bresp;
		bready <= 1'b0;
	endtask
	task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] resp);
		int n;
		n = 0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (rvalid !== 1'b1 && n < 60)
		begin
			@(posedge clk);
			n++;
			if (arready === 1'b1)
				arvalid <= 1'b0;
		end
		d = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask
	task automatic rdchk(input string what, input logic [3:0] a, input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0]  r;
		axr(a, d, r);
		chk(what, d, exp);
		chk("read response", r, RESP_OKAY);
	endtask
	// cycles from now until the chip reset lets go
	task automatic wait_rel(output int n);
		n = 0;
		while (chipResetN !== 1'b1 && n < 3000)
		begin
			@(posedge clk);
			n++;
		end
	endtask
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_bandgap;
		for (int i = 0; i < 8; i++)
		begin
			brownoutEnableFuse <= i[0];
			comparatorBandgapSelect <= i[1];
			adcEnable <= i[2];
			repeat (3) @(posedge clk);
			chk("bandgap enable", bandgapEnable, i != 0);
		end
		// leave brown-out detection off for the first pulse scenario
		brownoutEnableFuse <= 1'b0;
		comparatorBandgapSelect <= 1'b0;
		adcEnable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic t_pulse(input bit useBod, input int len, input bit expRst);
		int          n;
		logic        seen;
		logic [1:0]  r;
		seen = 1'b0;
		brownoutBelow <= useBod;
		resetPinN <= useBod;
		repeat (len)
		begin
			@(posedge clk);
			if (chipResetN === 1'b0 && ioResetN === 1'b0)
				seen = 1'b1;
		end
		brownoutBelow <= 1'b0;
		resetPinN <= 1'b1;
		wait_rel(n);
		chk(useBod ? "brownout reset" : "pin reset", seen, expRst);
		chk("release delay", expRst ? (n >= D && n <= D + 8) : (n <= 1), 1'b1);
		rdchk("cause flags", REG_STATUS, expRst ? (useBod ? 32'h4 : 32'h2) : 32'h0);
		axw(REG_STATUS, 8'h00, r);
	endtask
	task automatic t_watchdog;
		int          n;
		logic        seen;
		logic [1:0]  r;
		seen = 1'b0;
		axw(REG_WDCTL, 8'h08, r);
		// restarts closer than one period must keep the chip running
		repeat (12)
		begin
			repeat (1000)
			begin
				@(posedge clk);
				if (chipResetN !== 1'b1)
					seen = 1'b1;
			end
			watchdogRestart <= 1'b1;
			@(posedge clk);
			watchdogRestart <= 1'b0;
		end
		chk("restarted watchdog quiet", seen, 1'b0);
		n = 0;
		while (chipResetN === 1'b1 && n < WPER + 100)
		begin
			@(posedge clk);
			n++;
		end
		chk("expiry time", n >= WPER - 8 && n <= WPER + 16, 1'b1);
		wait_rel(n);
		chk("watchdog release delay", n >= D && n <= D + 8, 1'b1);
		rdchk("watchdog flag", REG_STATUS, 32'h8);
		rdchk("enable forced by flag", REG_WDCTL, 32'h8);
		axw(REG_STATUS, 8'h00, r);
		axw(REG_WDCTL, 8'h48, r);
		n = 0;
		while (watchdogIrq !== 1'b1 && n < WPER + 100)
		begin
			@(posedge clk);
			n++;
			if (chipResetN !== 1'b1)
				seen = 1'b1;
		end
		chk("interrupt instead of reset", {seen, watchdogIrq}, 2'b01);
		repeat (6) @(posedge clk);
		chk("interrupt acked", watchdogIrq, 1'b0);
		rdchk("interrupt enable dropped", REG_WDCTL, 32'h8);
	endtask
	task automatic t_misc;
		logic [31:0] d;
		logic [1:0]  r;
		axr(4'hc, d, r);
		chk("unmapped read", {r, d}, {RESP_SLVERR, 32'h0});
		axw(4'hc, 8'hff, r);
		chk("unmapped write", r, RESP_SLVERR);
		watchdogAlwaysOnFuse <= 1'b1;
		repeat (3) @(posedge clk);
		rdchk("safety level two", REG_SEQ, 32'h4);
		axr(REG_WDCTL, d, r);
		chk("enable reads one", d[WD_E], 1'b1);
		// open the timed sequence, then see change enable gone by itself
		axw(REG_WDCTL, 8'h18, r);
		repeat (8) @(posedge clk);
		rdchk("change enable self-cleared", REG_WDCTL, 32'h8);
	endtask
	task end_sim;
		$display("comparisons %0d mismatches %0d", cmpCount, badCount);
		if (badCount == 0 && cmpCount > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// main sequence and watchdog
	// ----------------------------------------------------------------
	initial
	begin
		int n;
		logic [1:0] r;
		{nrst, brownoutBelow, brownoutEnableFuse, watchdogAlwaysOnFuse} = 4'h0;
		{watchdogRestart, comparatorBandgapSelect, adcEnable} = 3'h0;
		{porActive, resetPinN, resetPinEnable} = 3'h7;
		startupTimeFuse = SUT_MIN;
		clockSelectFuse = CLOCK_SELECT_FUSE_EXTCLK;
		{awaddr, araddr, wdata, wstrb} = {8'h00, 32'h0, 4'hf};
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		repeat (6) @(posedge clk);
		chk("held by power-on", {chipResetN, ioResetN}, 2'b00);
		porActive <= 1'b0;
		wait_rel(n);
		chk("power-on delay", n >= D && n <= D + 8, 1'b1);
		rdchk("power-on flag", REG_STATUS, 32'h1);
		axw(REG_STATUS, 8'h00, r);
		rdchk("power-on flag cleared", REG_STATUS, 32'h0);
		t_bandgap();
		t_pulse(1'b1, 500, 1'b0);
		brownoutEnableFuse <= 1'b1;
		t_pulse(1'b1, 100, 1'b0);
		t_pulse(1'b1, 500, 1'b1);
		t_pulse(1'b0, 100, 1'b0);
		t_pulse(1'b0, 600, 1'b1);
		resetPinEnable <= 1'b0;
		t_pulse(1'b0, 600, 1'b0);
		t_watchdog();
		t_misc();
		end_sim();
	end
	initial
	begin
		repeat (60000) @(posedge clk);
		badCount++;
		$display("[ERR] run length expected done seen hung");
		end_sim();
	end
endmodule
